// >>> drcr_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// keypad and terminal panel: each key press is held a few cycles
module drcr_panel (
  // clock
  input  wire logic       mclk,
  // bench requests
  input  wire logic       run_req,
  input  wire logic       halt_req,
  input  wire logic [2:0] lvl,
  // pins toward the drive
  output logic            run_key,
  output logic            halt_key,
  output logic            term_one,
  output logic            term_two,
  output logic            fault
);
  int run_n = 0;
  int halt_n = 0;
  // a one cycle press could slip past the pin sampler
  always @(posedge mclk)
  begin
    run_n <= run_req ? 4 : (run_n > 0 ? run_n - 1 : 0);
    halt_n <= halt_req ? 4 : (halt_n > 0 ? halt_n - 1 : 0);
  end
  // keys idle low between presses; switches are levels
  assign run_key = run_n > 0;
  assign halt_key = halt_n > 0;
  assign {fault, term_two, term_one} = lvl;
endmodule : drcr_panel
`default_nettype wire

// >>> drcr_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the run command and ramp block
package drcr_pkg;
  // frequency in 0.1 Hz steps, ramp times as raw unit counts
  localparam int FW = 12;
  localparam int TW = 16;
  localparam int CW = 48;
  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_ACC    = 8'h04;
  localparam logic [7:0] A_DEC    = 8'h08;
  localparam logic [7:0] A_MAXF   = 8'h0c;
  localparam logic [7:0] A_TARGET = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  // control field positions
  localparam int C_SRC = 0;
  localparam int C_DIR = 2;
  localparam int C_INH = 3;
  localparam int C_IN1 = 5;
  localparam int C_IN2 = 10;
  localparam int C_PON = 15;
  localparam int C_FRS = 16;
  localparam int C_REF = 17;
  localparam int C_RES = 18;
  // reset values and write limits
  localparam logic [1:0]    SRC_RST  = 2'h1;
  localparam logic [4:0]    IN1_RST  = 5'h00;
  localparam logic [4:0]    IN2_RST  = 5'h01;
  localparam logic [1:0]    RES_RST  = 2'h1;
  localparam logic [TW-1:0] ACC_RST  = 16'h0032;
  localparam logic [TW-1:0] DEC_RST  = 16'h0064;
  localparam logic [FW-1:0] MAXF_RST = 12'h258;
  localparam logic [FW-1:0] MAXF_MAX = 12'hfa0;
  localparam logic [TW-1:0] TIME_MAX = 16'hea60;
  // run sources, inhibit codes, terminal functions, ramp time resolutions
  localparam logic [1:0] SRC_KEY  = 2'h0;
  localparam logic [1:0] SRC_TWO  = 2'h1;
  localparam logic [1:0] SRC_DIR  = 2'h2;
  localparam logic [1:0] INH_FWD  = 2'h1;
  localparam logic [1:0] INH_REV  = 2'h2;
  localparam logic [4:0] FUNC_FWD = 5'h00;
  localparam logic [4:0] FUNC_REV = 5'h01;
  localparam logic [1:0] RES_10MS = 2'h0;
  localparam logic [1:0] RES_100MS = 2'h1;
  // timing: base time unit 0.01 s at 125 MHz
  localparam int CLK_MHZ  = 125;
  localparam int UNIT_US  = 10000;
  localparam int UNIT_CYC = CLK_MHZ * UNIT_US;
  // run state
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_RUN   = 2'b01,
    RS_FAULT = 2'b10
  } drcr_run_t;
endpackage : drcr_pkg
`default_nettype wire

// >>> drcr_ramp.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// fixed rate ramp: span steps spread over total cycles
module drcr_ramp #(
  parameter int FW = 12,
  parameter int CW = 48
) (
  // clock and reset
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  // ramp control
  input  wire logic [FW-1:0] SP,
  input  wire logic [FW-1:0] SPAN,
  input  wire logic [CW-1:0] TOTAL,
  input  wire logic          RESTART,
  input  wire logic          ZERO,
  // present output frequency
  output logic      [FW-1:0] FREQ
);
  typedef struct packed {
    logic [FW-1:0] freq;
    logic [CW-1:0] acc;
  } drcr_ramp_t;

  drcr_ramp_t st_ff;
  drcr_ramp_t nxt_st;
  logic [CW-1:0] sum;
  logic [CW-1:0] span_w;

  // dda: one step each time the sum passes total
  always_comb
  begin
    nxt_st = st_ff;
    span_w = CW'(SPAN);
    sum    = st_ff.acc + span_w;
    if (ZERO)
    begin
      nxt_st.freq = '0;
      nxt_st.acc  = '0;
    end
    else if (RESTART || st_ff.freq == SP)
      nxt_st.acc = '0;
    else if (TOTAL == '0 || span_w > TOTAL) // zero time, or more than one step every cycle
      nxt_st.freq = SP; // too short to ramp, jump
    else if (sum >= TOTAL)
    begin
      nxt_st.acc = sum - TOTAL;
      if (SP > st_ff.freq)
        nxt_st.freq = st_ff.freq + 1'b1;
      else
        nxt_st.freq = st_ff.freq - 1'b1;
    end
    else
      nxt_st.acc = sum;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign FREQ = st_ff.freq;

  // ==========================================================
  // checks
  step_size_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!ZERO && TOTAL > CW'(SPAN) && $past(TOTAL) > CW'($past(SPAN))
     && $stable(SP) && !$past(ZERO))
    |-> (FREQ - $past(FREQ) <= FW'(1) || $past(FREQ) - FREQ <= FW'(1)))
    else $error("ramp moved more than one step");
  no_overshoot_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($past(FREQ) <= $past(SP) && $stable(SP) && !$past(ZERO))
    |-> FREQ <= SP)
    else $error("ramp passed its setpoint");
endmodule : drcr_ramp
`default_nettype wire

// >>> drcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flop synchroniser for one pin level
module drcr_sync (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // pin and clean level
  input  wire logic D,
  output logic      Q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } drcr_sync_t;

  drcr_sync_t st_ff;
  drcr_sync_t nxt_st;

  // first stage feeds only the second
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = D;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign Q = st_ff.s2;
endmodule : drcr_sync
`default_nettype wire

// >>> drcr_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// run command selection and ramp time control
module drcr_top #(
  parameter int unsigned UNIT_CYC = drcr_pkg::UNIT_CYC
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // keypad keys and terminal pins
  input  wire logic        RUN_KEY,
  input  wire logic        HALT_KEY,
  input  wire logic        MULTIFUNCTION_INPUT_ONE,
  input  wire logic        MULTIFUNCTION_INPUT_TWO,
  input  wire logic        FAULT,
  // drive outputs
  output logic      [11:0] FREQ_OUT,
  output logic             DIR_REV,
  output logic             RUNNING
);
  typedef struct packed {
    logic                      ack;
    logic [31:0]               dat;
    logic [1:0]                src;
    logic                      dir_sel;
    logic [1:0]                inh;
    logic [4:0]                in1;
    logic [4:0]                in2;
    logic                      pon;
    logic                      frs;
    logic                      ref_sel;
    logic [1:0]                res;
    logic [drcr_pkg::TW-1:0]   acc_t;
    logic [drcr_pkg::TW-1:0]   dec_t;
    logic [drcr_pkg::FW-1:0]   maxf;
    logic [drcr_pkg::FW-1:0]   target;
    drcr_pkg::drcr_run_t       state;
    logic                      key_run;
    logic                      arm;
    logic [1:0]                pwr_cnt;
    logic                      run_d;
    logic                      halt_d;
    logic                      dir_out;
    logic [drcr_pkg::FW-1:0]   sp_d;
    logic                      up_d;
    logic [drcr_pkg::FW-1:0]   span;
  } drcr_top_t;

  drcr_top_t st_ff;
  drcr_top_t nxt_st;

  logic                    run_s;
  logic                    halt_s;
  logic                    in1_s;
  logic                    in2_s;
  logic                    fault_s;
  logic [drcr_pkg::FW-1:0] freq;
  logic                    fwd_t;
  logic                    rev_t;
  logic                    term;
  logic                    cmd;
  logic                    dir;
  logic                    allowed;
  logic                    want;
  logic [drcr_pkg::FW-1:0] tgt;
  logic [drcr_pkg::FW-1:0] sp;
  logic                    up;
  logic [drcr_pkg::TW-1:0] tsel;
  logic [31:0]             unit_mult;
  logic [drcr_pkg::CW-1:0] total;
  logic [drcr_pkg::FW-1:0] span_use;
  logic                    restart;
  logic                    req;
  logic [31:0]             rd;
  logic [31:0]             wmask;
  logic [31:0]             ctrl;
  logic [31:0]             wv;
  logic                    pwr_now;
  logic                    fault_clr;

  // ==========================================================
  // pin synchronisers
  drcr_sync u_sync_run (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (RUN_KEY),
    .Q     (run_s)
  );
  drcr_sync u_sync_halt (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (HALT_KEY),
    .Q     (halt_s)
  );
  drcr_sync u_sync_in1 (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (MULTIFUNCTION_INPUT_ONE),
    .Q     (in1_s)
  );
  drcr_sync u_sync_in2 (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (MULTIFUNCTION_INPUT_TWO),
    .Q     (in2_s)
  );
  drcr_sync u_sync_flt (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .D     (FAULT),
    .Q     (fault_s)
  );

  // ==========================================================
  // ramp engine
  drcr_ramp #(
    .FW (drcr_pkg::FW),
    .CW (drcr_pkg::CW)
  ) u_ramp (
    .MCLK    (MCLK),
    .RST_N   (RST_N),
    .SP      (sp),
    .SPAN    (span_use),
    .TOTAL   (total),
    .RESTART (restart),
    .ZERO    (fault_s),
    .FREQ    (freq)
  );

  // ==========================================================
  // register view of the control bits
  always_comb
  begin
    ctrl = '0;
    ctrl[drcr_pkg::C_SRC +: 2] = st_ff.src;
    ctrl[drcr_pkg::C_DIR]      = st_ff.dir_sel;
    ctrl[drcr_pkg::C_INH +: 2] = st_ff.inh;
    ctrl[drcr_pkg::C_IN1 +: 5] = st_ff.in1;
    ctrl[drcr_pkg::C_IN2 +: 5] = st_ff.in2;
    ctrl[drcr_pkg::C_PON]      = st_ff.pon;
    ctrl[drcr_pkg::C_FRS]      = st_ff.frs;
    ctrl[drcr_pkg::C_REF]      = st_ff.ref_sel;
    ctrl[drcr_pkg::C_RES +: 2] = st_ff.res;
  end

  // read mux and byte lane mask; unmapped reads give zero
  always_comb
  begin
    wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    rd    = '0;
    if (ADR_I == drcr_pkg::A_CTRL)
      rd = ctrl;
    else if (ADR_I == drcr_pkg::A_ACC)
      rd = 32'(st_ff.acc_t);
    else if (ADR_I == drcr_pkg::A_DEC)
      rd = 32'(st_ff.dec_t);
    else if (ADR_I == drcr_pkg::A_MAXF)
      rd = 32'(st_ff.maxf);
    else if (ADR_I == drcr_pkg::A_TARGET)
      rd = 32'(st_ff.target);
    else if (ADR_I == drcr_pkg::A_STATUS)
      rd = {16'h0000, fault_s, st_ff.state, st_ff.dir_out, freq};
  end

  // ==========================================================
  // run command decode
  always_comb
  begin
    // terminal roles follow the function codes
    fwd_t = (st_ff.in1 == drcr_pkg::FUNC_FWD) && in1_s;
    rev_t = (st_ff.in2 == drcr_pkg::FUNC_REV) && in2_s;
    term  = (st_ff.src == drcr_pkg::SRC_TWO)
         || (st_ff.src == drcr_pkg::SRC_DIR);
    case (st_ff.src)
      drcr_pkg::SRC_KEY:
      begin
        cmd = st_ff.key_run;
        dir = st_ff.dir_sel;
      end
      drcr_pkg::SRC_TWO:
      begin
        cmd = fwd_t ^ rev_t;
        dir = rev_t;
      end
      drcr_pkg::SRC_DIR:
      begin
        cmd = fwd_t;
        dir = rev_t;
      end
      default:
      begin
        cmd = 1'b0;
        dir = 1'b0;
      end
    endcase
    // direction inhibit
    allowed = !(!dir && st_ff.inh == drcr_pkg::INH_FWD)
           && !(dir && st_ff.inh == drcr_pkg::INH_REV);
    // a terminal command only counts once armed
    want = cmd && allowed && (!term || st_ff.arm)
        && st_ff.pwr_cnt == 2'h3 && !fault_s;
    tgt  = (st_ff.target > st_ff.maxf) ? st_ff.maxf : st_ff.target;
    // reversal waits at zero before the direction flips
    sp   = (want && dir == st_ff.dir_out) ? tgt : '0;
    up   = want && (sp > freq);
  end

  // ==========================================================
  // ramp timing: unit per resolution, time per direction of change
  always_comb
  begin
    if (st_ff.res == drcr_pkg::RES_10MS)
      unit_mult = UNIT_CYC;
    else if (st_ff.res == drcr_pkg::RES_100MS)
      unit_mult = 32'(UNIT_CYC * 10);
    else
      unit_mult = 32'(UNIT_CYC * 100);
    tsel     = up ? st_ff.acc_t : st_ff.dec_t;
    total    = drcr_pkg::CW'(tsel) * drcr_pkg::CW'(unit_mult);
    // full scale span, or the latched delta of this change
    span_use = st_ff.ref_sel ? st_ff.span : st_ff.maxf;
    restart  = (sp != st_ff.sp_d) || (up != st_ff.up_d);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st    = st_ff;
    req       = CYC_I && STB_I;
    wv        = DAT_I & wmask;
    pwr_now   = (st_ff.pwr_cnt == 2'h2);
    fault_clr = (st_ff.state == drcr_pkg::RS_FAULT) && !fault_s;
    // single wait state, ack dropped the cycle after
    nxt_st.ack = req && !st_ff.ack;
    if (req && !st_ff.ack)
      nxt_st.dat = rd;
    // writes land at the edge where ack is seen high
    if (req && st_ff.ack && WE_I)
    begin
      if (ADR_I == drcr_pkg::A_CTRL)
      begin
        wv = (ctrl & ~wmask) | wv;
        nxt_st.src     = wv[drcr_pkg::C_SRC +: 2];
        nxt_st.dir_sel = wv[drcr_pkg::C_DIR];
        nxt_st.inh     = wv[drcr_pkg::C_INH +: 2];
        nxt_st.in1     = wv[drcr_pkg::C_IN1 +: 5];
        nxt_st.in2     = wv[drcr_pkg::C_IN2 +: 5];
        nxt_st.pon     = wv[drcr_pkg::C_PON];
        nxt_st.frs     = wv[drcr_pkg::C_FRS];
        nxt_st.ref_sel = wv[drcr_pkg::C_REF];
        nxt_st.res     = wv[drcr_pkg::C_RES +: 2];
      end
      else if (ADR_I == drcr_pkg::A_ACC)
      begin
        wv = (32'(st_ff.acc_t) & ~wmask) | wv;
        nxt_st.acc_t = (wv > 32'(drcr_pkg::TIME_MAX))
                     ? drcr_pkg::TIME_MAX : wv[15:0];
      end
      else if (ADR_I == drcr_pkg::A_DEC)
      begin
        wv = (32'(st_ff.dec_t) & ~wmask) | wv;
        nxt_st.dec_t = (wv > 32'(drcr_pkg::TIME_MAX))
                     ? drcr_pkg::TIME_MAX : wv[15:0];
      end
      else if (ADR_I == drcr_pkg::A_MAXF)
      begin
        wv = (32'(st_ff.maxf) & ~wmask) | wv;
        nxt_st.maxf = (wv > 32'(drcr_pkg::MAXF_MAX))
                    ? drcr_pkg::MAXF_MAX : wv[11:0];
      end
      else if (ADR_I == drcr_pkg::A_TARGET)
      begin
        wv = (32'(st_ff.target) & ~wmask) | wv;
        nxt_st.target = (wv > 32'(drcr_pkg::MAXF_MAX))
                      ? drcr_pkg::MAXF_MAX : wv[11:0];
      end
    end
    // keypad keys: halt wins over run in the same cycle
    nxt_st.run_d  = run_s;
    nxt_st.halt_d = halt_s;
    if (run_s && !st_ff.run_d)
      nxt_st.key_run = 1'b1;
    if ((halt_s && !st_ff.halt_d) || st_ff.src != drcr_pkg::SRC_KEY
        || fault_s)
      nxt_st.key_run = 1'b0;
    // arming: a released terminal arms; power-up and fault clear
    // arm only when their auto option allows
    if (st_ff.pwr_cnt != 2'h3)
      nxt_st.pwr_cnt = st_ff.pwr_cnt + 2'h1;
    if (term && !cmd)
      nxt_st.arm = 1'b1;
    else if (pwr_now)
      nxt_st.arm = term && st_ff.pon;
    else if (fault_clr)
      nxt_st.arm = term && st_ff.frs;
    // run state
    case (st_ff.state)
      drcr_pkg::RS_IDLE:
        if (fault_s)
          nxt_st.state = drcr_pkg::RS_FAULT;
        else if (want)
          nxt_st.state = drcr_pkg::RS_RUN;
      drcr_pkg::RS_RUN:
        if (fault_s)
          nxt_st.state = drcr_pkg::RS_FAULT;
        else if (!want && freq == '0)
          nxt_st.state = drcr_pkg::RS_IDLE;
      drcr_pkg::RS_FAULT:
        if (!fault_s)
          nxt_st.state = drcr_pkg::RS_IDLE;
      default:
        nxt_st.state = drcr_pkg::RS_IDLE;
    endcase
    // direction only turns at standstill
    if (freq == '0 && want)
      nxt_st.dir_out = dir;
    // latch the delta of each new change
    nxt_st.sp_d = sp;
    nxt_st.up_d = up;
    if (restart)
      nxt_st.span = (sp > freq) ? sp - freq : freq - sp;
  end

  // ==========================================================
  // state register with documented reset values
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_ff        <= '0;
      st_ff.src    <= drcr_pkg::SRC_RST;
      st_ff.in1    <= drcr_pkg::IN1_RST;
      st_ff.in2    <= drcr_pkg::IN2_RST;
      st_ff.res    <= drcr_pkg::RES_RST;
      st_ff.acc_t  <= drcr_pkg::ACC_RST;
      st_ff.dec_t  <= drcr_pkg::DEC_RST;
      st_ff.maxf   <= drcr_pkg::MAXF_RST;
      st_ff.state  <= drcr_pkg::RS_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign ACK_O    = st_ff.ack;
  assign DAT_O    = st_ff.dat;
  assign FREQ_OUT = freq;
  assign DIR_REV  = st_ff.dir_out;
  assign RUNNING  = (st_ff.state == drcr_pkg::RS_RUN);

  // ==========================================================
  // checks
  ack_pulse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ACK_O |=> !ACK_O)
    else $error("ack held two cycles");
  src_reset_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(RST_N) |-> st_ff.src == drcr_pkg::SRC_RST)
    else $error("source not one after reset");
  both_on_stop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_ff.src == drcr_pkg::SRC_TWO && fwd_t && rev_t) |-> sp == '0)
    else $error("run with both terminals on");
  inhibit_fwd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_ff.inh == drcr_pkg::INH_FWD && !dir) |-> !want)
    else $error("forward run while inhibited");
  inhibit_rev_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_ff.inh == drcr_pkg::INH_REV && dir) |-> !want)
    else $error("reverse run while inhibited");
  halt_key_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (halt_s && !st_ff.halt_d) |=> !st_ff.key_run)
    else $error("halt key did not drop the run");
  pon_keypad_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_ff.src == drcr_pkg::SRC_KEY && !st_ff.key_run) |-> !want)
    else $error("terminal started a keypad drive");
  fault_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    fault_s |=> freq == '0 && !RUNNING)
    else $error("output not zero in fault");
  dec_on_stop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!want && freq != '0) |-> tsel == st_ff.dec_t)
    else $error("stop not using slowdown time");
  unmapped_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CYC_I && STB_I && !ACK_O && ADR_I > drcr_pkg::A_STATUS)
    |=> DAT_O == '0)
    else $error("unmapped read not zero");
  run_seen_c: cover property (@(posedge MCLK) disable iff (!RST_N)
    $rose(RUNNING));
  reverse_c: cover property (@(posedge MCLK) disable iff (!RST_N)
    $rose(DIR_REV));
  restart_c: cover property (@(posedge MCLK) disable iff (!RST_N)
    fault_clr && st_ff.frs && term);
endmodule : drcr_top
`default_nettype wire

// >>> drcr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the run command and ramp block
module drcr_top_tb;
  logic        mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic        run_req = 0, halt_req = 0, ack, rk, hk, t1, t2, flt;
  logic        rev, running;
  logic [2:0]  lvl = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0, rd, dat_o;
  logic [11:0] freq;
  int          bad_count = 0, checks = 0, n, src, inh, dir, f, r, tg;
  logic [1:0]  e;
  // ==========================================================
  // clock, parts
  initial forever #4 mclk = ~mclk;
  drcr_panel PNL (.mclk(mclk), .run_req(run_req), .halt_req(halt_req),
    .lvl(lvl), .run_key(rk), .halt_key(hk), .term_one(t1),
    .term_two(t2), .fault(flt));
  drcr_top #(.UNIT_CYC(4)) DUT (.MCLK(mclk), .RST_N(rst_n), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd),
    .DAT_O(dat_o), .ACK_O(ack), .RUN_KEY(rk), .HALT_KEY(hk),
    .MULTIFUNCTION_INPUT_ONE(t1), .MULTIFUNCTION_INPUT_TWO(t2),
    .FAULT(flt), .FREQ_OUT(freq), .DIR_REV(rev), .RUNNING(running));
  // ==========================================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] x, input string m);
    checks++;
    if (got !== x)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, x);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge mclk);
    if (n >= 50)
      chk(0, 1, "no ack");
  endtask : wb
  task press(input logic h);
    if (h)
      halt_req <= 1;
    else
      run_req <= 1;
    @(posedge mclk);
    halt_req <= 0;
    run_req <= 0;
  endtask : press
  // counts cycles until the output frequency reaches a value
  task wait_f(input logic [11:0] x);
    n = 0;
    while (freq !== x && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_f
  task ramp(input int x, input string m);
    chk(32'(n >= x && n <= x + 14), 1, m);
    $display("test %s done", m);
  endtask : ramp
  // expected run and reverse from source, inhibit, key and terminals
  function automatic logic [1:0] mdl(input int s, i, d, a, b);
    int run, rv;
    run = s == 0 ? 1 : (s == 1 ? a ^ b : (s == 2 ? a : 0));
    rv = s == 0 ? d : b;
    if ((i == 1 && rv == 0) || (i == 2 && rv == 1))
      run = 0;
    return {run[0], rv[0]};
  endfunction : mdl
  task wrap_up;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // watchdog, sized well beyond the longest sequence
  initial
  begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hce1a61bb));
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    wb(0, 8'h00, 0);
    chk(rd, 32'h00040401, "ctrl reset");
    wb(0, 8'h04, 0);
    chk(rd, 50, "speedup reset");
    wb(0, 8'h08, 0);
    chk(rd, 100, "slowdown reset");
    wb(0, 8'h0c, 0);
    chk(rd, 600, "max reset");
    wb(1, 8'h0c, 32'hfff);
    wb(0, 8'h0c, 0);
    chk(rd, 4000, "max");
    wb(1, 8'h20, 32'h5);
    wb(0, 8'h20, 0);
    chk(rd, 0, "unmapped");
    wb(1, 8'h0c, 600);
    wb(1, 8'h04, 0);
    wb(1, 8'h08, 0);
    $display("test registers done");
    // every source against every inhibit code, jumps with zero times
    for (int i = 0; i < 12; i++)
    begin
      src = i % 4;
      inh = (i / 4) % 3;
      dir = $urandom % 2;
      f = $urandom % 2;
      r = $urandom % 2;
      tg = 1 + $urandom % 599;
      lvl <= 0;
      wb(1, 8'h00, src | dir << 2 | inh << 3 | 32'h400);
      wb(1, 8'h10, tg);
      lvl <= {1'b0, r[0], f[0]};
      if (src == 0)
        press(0);
      e = mdl(src, inh, dir, f, r);
      wait_f(e[1] ? tg[11:0] : 12'h0);
      repeat (8) @(posedge mclk);
      chk(freq, e[1] ? tg : 0, "run freq");
      chk(running, e[1], "running");
      if (e[1])
        chk(rev, e[0], "direction");
      if (src == 0)
        press(1);
    end
    lvl <= 0;
    $display("test sources done");
    // full span 600 over 1200 cycles: 300 steps take 600
    for (int k = 0; k < 3; k++)
    begin
      wb(1, 8'h00, k << 18);
      wb(1, 8'h04, k == 0 ? 300 : (k == 1 ? 30 : 3));
      wb(1, 8'h10, 300);
      press(0);
      wait_f(300);
      ramp(600, "max reference");
      press(1);
      wait_f(0);
    end
    // delta reference: each change takes the whole programmed time
    wb(1, 8'h00, 32'h20000);
    wb(1, 8'h04, 300);
    wb(1, 8'h10, 100);
    press(0);
    wait_f(100);
    ramp(1200, "delta small");
    wb(1, 8'h10, 400);
    wait_f(400);
    ramp(1200, "delta large");
    wb(0, 8'h14, 0);
    chk(rd, 32'h00002190, "status");
    wb(1, 8'h00, 0);
    wb(1, 8'h08, 150);
    press(1);
    wait_f(0);
    ramp(400, "slowdown");
    // restart on fault clear only under terminal control
    wb(1, 8'h08, 0);
    wb(1, 8'h04, 0);
    wb(1, 8'h10, 200);
    wb(1, 8'h00, 32'h10401);
    lvl <= 3'b001;
    wait_f(200);
    lvl <= 3'b101;
    wait_f(0);
    chk(freq, 0, "trip");
    lvl <= 3'b001;
    wait_f(200);
    chk(freq, 200, "autorestart");
    // same trip with the restart option off: no run until released
    lvl <= 3'b101;
    wb(1, 8'h00, 32'h00401);
    wait_f(0);
    lvl <= 3'b001;
    repeat (40) @(posedge mclk);
    chk(freq, 0, "no autorestart");
    lvl <= 0;
    wb(1, 8'h00, 32'h10400);
    press(0);
    wait_f(200);
    lvl <= 3'b100;
    wait_f(0);
    lvl <= 0;
    repeat (40) @(posedge mclk);
    chk(freq, 0, "keypad no restart");
    // input one with a non-run function code gives no command
    wb(1, 8'h00, 32'h442);
    lvl <= 3'b001;
    repeat (12) @(posedge mclk);
    chk(freq, 0, "input one role");
    lvl <= 0;
    $display("test fault done");
    wrap_up();
  end
endmodule : drcr_top_tb
`default_nettype wire
